// File: core/ucpmc_mode_ctrl.v
// Mode control for a USB charge-port buck regulator
`timescale 1ns/10ps
`include "ucpmc_defs.vh"

module ucpmc_mode_ctrl #(
  parameter DEGLITCH_CYC = `UCPMC_DEGLITCH_CYC,
  parameter CNT_W        = 23
) (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        modeSelectHi,
  input  wire        modeSelectLo,
  input  wire        enableAboveThr,
  input  wire        vinUvlo,
  input  wire        vccUvlo,
  input  wire        overtempTrip,
  input  wire        overtempCool,
  input  wire        syncClockValid,
  input  wire        currentLimitActive,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire        avs_waitrequest,
  output reg  [31:0] avs_readdata,
  output reg         avs_response,
  output reg         buckEnable,
  output reg         forcedContinuousPwm,
  output reg         freqLockSync,
  output reg  [3:0]  ditherStep,
  output reg         loadSwitchGate,
  output reg         dataSwitchOn,
  output reg         activeMode
);

  // ------------------------------------------------------------
  // Mode-select synchroniser
  // ------------------------------------------------------------
  wire [1:0]             selPins;
  reg  [1:0]             selMeta_q;
  reg  [1:0]             selSync_q;
  reg  [1:0]             selPrev_q;

  assign selPins = {modeSelectHi, modeSelectLo};

  genvar                 gi;

  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : gSync
      always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          selMeta_q[gi] <= 1'b0;
          selSync_q[gi] <= 1'b0;
        end else begin
          selMeta_q[gi] <= selPins[gi];
          selSync_q[gi] <= selMeta_q[gi];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Pattern history for change detection
  // ------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      selPrev_q <= 2'h0;
    end else begin
      selPrev_q <= selSync_q;
    end
  end

  // ------------------------------------------------------------
  // Mode state machine and deglitch
  // ------------------------------------------------------------
  reg  [`UCPMC_ST_W-1:0] mode_q;
  reg  [`UCPMC_ST_W-1:0] mode_d;
  reg  [CNT_W-1:0]       dglCnt_q;
  reg  [CNT_W-1:0]       dglCnt_d;
  wire                   selClient;
  wire                   selChanged;

  assign selClient  = ~selSync_q[1];
  assign selChanged = selSync_q != selPrev_q;

  always @* begin
    mode_d   = mode_q;
    dglCnt_d = {CNT_W{1'b0}};
    case (mode_q)
      `UCPMC_ST_CLIENT: begin
        if (selSync_q == `UCPMC_SEL_SDP) begin
          mode_d = `UCPMC_ST_SDP;
        end else if (selSync_q == `UCPMC_SEL_CDP) begin
          mode_d = `UCPMC_ST_CDP;
        end
      end
      `UCPMC_ST_SDP, `UCPMC_ST_CDP: begin
        if (selClient) begin
          if (selChanged) begin
            dglCnt_d = {CNT_W{1'b0}};
          end else if (dglCnt_q >= DEGLITCH_CYC - 1) begin
            mode_d = `UCPMC_ST_CLIENT;
          end else begin
            dglCnt_d = dglCnt_q + 1'b1;
          end
        end else if (selSync_q == `UCPMC_SEL_SDP) begin
          mode_d = `UCPMC_ST_SDP;
        end else begin
          mode_d = `UCPMC_ST_CDP;
        end
      end
      default: begin
        mode_d = `UCPMC_ST_RESET;
      end
    endcase
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= `UCPMC_ST_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dglCnt_q <= {CNT_W{1'b0}};
    end else begin
      dglCnt_q <= dglCnt_d;
    end
  end

  // ------------------------------------------------------------
  // Over-temperature latch with hysteresis
  // ------------------------------------------------------------
  reg                    otShut_q;

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      otShut_q <= 1'b0;
    end else if (overtempTrip) begin
      otShut_q <= 1'b1;
    end else if (overtempCool) begin
      otShut_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Register slave
  // ------------------------------------------------------------
  reg  [31:0]            ctrl_q;
  reg                    rdValid_q;
  wire                   ditherEn;
  wire                   ctrlWrite;
  wire [31:0]            statusWord;

  // Reads take one wait state so that read data come from a flip-flop
  assign avs_waitrequest = avs_read & ~rdValid_q;
  assign ditherEn        = ctrl_q[`UCPMC_CTRL_DITHER];
  assign ctrlWrite       = avs_write & ~avs_read & (avs_address == `UCPMC_REG_CTRL);

  // ------------------------------------------------------------
  // Status word
  // ------------------------------------------------------------
  assign statusWord = {21'h0, ditherStep, otShut_q, activeMode,
                       dataSwitchOn, buckEnable, mode_q};

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= `UCPMC_CTRL_RESET;
    end else if (ctrlWrite && avs_byteenable[0]) begin
      ctrl_q[`UCPMC_CTRL_DITHER] <= avs_writedata[`UCPMC_CTRL_DITHER];
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= avs_read & ~rdValid_q;
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !rdValid_q) begin
      if (avs_address == `UCPMC_REG_STATUS) begin
        avs_readdata <= statusWord;
      end else if (avs_address == `UCPMC_REG_CTRL) begin
        avs_readdata <= ctrl_q;
      end else begin
        avs_readdata <= 32'h00000000;
      end
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      avs_response <= 1'b0;
    end else begin
      avs_response <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Operating mode
  // ------------------------------------------------------------
  wire                   active;
  wire                   buckRun;

  assign active  = enableAboveThr & ~vinUvlo & ~vccUvlo;
  assign buckRun = active & ~otShut_q & ~mode_q[0];

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      activeMode <= 1'b0;
    end else begin
      activeMode <= active;
    end
  end

  // ------------------------------------------------------------
  // Buck regulator enable
  // ------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      buckEnable <= 1'b0;
    end else begin
      buckEnable <= buckRun;
    end
  end

  // ------------------------------------------------------------
  // Forced continuous conduction
  // ------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      forcedContinuousPwm <= 1'b0;
    end else begin
      forcedContinuousPwm <= buckRun;
    end
  end

  // ------------------------------------------------------------
  // Load-switch gate
  // ------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      loadSwitchGate <= 1'b0;
    end else begin
      loadSwitchGate <= buckRun;
    end
  end

  // ------------------------------------------------------------
  // External frequency lock
  // ------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      freqLockSync <= 1'b0;
    end else begin
      freqLockSync <= buckRun & syncClockValid;
    end
  end

  // ------------------------------------------------------------
  // Spread-spectrum dither
  // ------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ditherStep <= 4'h0;
    end else if (buckRun && ditherEn) begin
      ditherStep <= ditherStep + 4'h1;
    end else begin
      ditherStep <= 4'h0;
    end
  end

  // ------------------------------------------------------------
  // Data-line switches
  // ------------------------------------------------------------
  wire                   switchHold;

  // Current limiting has no effect: the switches follow enableAboveThr
  assign switchHold = currentLimitActive & enableAboveThr;

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dataSwitchOn <= 1'b0;
    end else begin
      dataSwitchOn <= enableAboveThr | switchHold;
    end
  end

endmodule // ucpmc_mode_ctrl

// File: core/ucpmc_defs.vh
// Constants for the charge-port mode control block
`ifndef UCPMC_DEFS_VH
`define UCPMC_DEFS_VH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define UCPMC_CLK_HZ          40000000
`define UCPMC_DEGLITCH_MS     150
`define UCPMC_DEGLITCH_CYC    ((`UCPMC_CLK_HZ / 1000) * `UCPMC_DEGLITCH_MS)

// ------------------------------------------------------------
// Mode-select patterns {hi, lo}
// ------------------------------------------------------------
`define UCPMC_SEL_CLIENT0     2'h0
`define UCPMC_SEL_CLIENT1     2'h1
`define UCPMC_SEL_SDP         2'h2
`define UCPMC_SEL_CDP         2'h3

// ------------------------------------------------------------
// One-hot mode states
// ------------------------------------------------------------
`define UCPMC_ST_W            3
`define UCPMC_ST_CLIENT       3'h1
`define UCPMC_ST_SDP          3'h2
`define UCPMC_ST_CDP          3'h4
`define UCPMC_ST_RESET        `UCPMC_ST_CLIENT

// ------------------------------------------------------------
// Avalon register map (byte addresses)
// ------------------------------------------------------------
`define UCPMC_ADDR_W          4
`define UCPMC_REG_STATUS      4'h0
`define UCPMC_REG_CTRL        4'h4
`define UCPMC_CTRL_RESET      32'h00000001
`define UCPMC_CTRL_DITHER     0
`define UCPMC_DITHER_W        4

`endif

// File: testbench/ucpmc_props_properties.sv
// Checker for the charge-port mode control outputs
`timescale 1ns/10ps
module ucpmc_props #(parameter DEGLITCH_CYC = 20) (
  input wire clk_sys, sys_rst, modeSelectHi, enableAboveThr, vinUvlo, vccUvlo,
  input wire overtempTrip, overtempCool, syncClockValid, buckEnable, forcedContinuousPwm,
  input wire freqLockSync, loadSwitchGate, dataSwitchOn, activeMode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire good = enableAboveThr && !vinUvlo && !vccUvlo;
  property p_ds_off; !enableAboveThr |=> !dataSwitchOn; endproperty
  a_ds_off: assert property (p_ds_off) else $error("switch not open");
  property p_ds_on; enableAboveThr |=> dataSwitchOn; endproperty
  a_ds_on: assert property (p_ds_on) else $error("switch not closed");
  property p_act_on; good |=> activeMode; endproperty
  a_act_on: assert property (p_act_on) else $error("not active");
  property p_act_off; !good [*2] |=> !activeMode && !buckEnable; endproperty
  a_act_off: assert property (p_act_off) else $error("not shut down");
  property p_otp; (overtempTrip && !overtempCool) [*2] |=> !loadSwitchGate && !buckEnable; endproperty
  a_otp: assert property (p_otp) else $error("runs while hot");
  property p_same; buckEnable == loadSwitchGate && buckEnable == forcedContinuousPwm; endproperty
  a_same: assert property (p_same) else $error("gate and buck differ");
  property p_sync; freqLockSync |-> buckEnable && $past(syncClockValid); endproperty
  a_sync: assert property (p_sync) else $error("lock without clock");
  property p_hold;
    $fell(modeSelectHi) ##0 buckEnable ##1 (good && !overtempTrip && !modeSelectHi) [*8] |-> buckEnable;
  endproperty
  a_hold: assert property (p_hold) else $error("client too early");
endmodule // ucpmc_props
bind ucpmc_mode_ctrl ucpmc_props #(.DEGLITCH_CYC(20)) i_props (.clk_sys, .sys_rst, .modeSelectHi,
  .enableAboveThr, .vinUvlo, .vccUvlo, .overtempTrip, .overtempCool, .syncClockValid, .buckEnable,
  .forcedContinuousPwm, .freqLockSync, .loadSwitchGate, .dataSwitchOn, .activeMode);

// File: testbench/ucpmc_sys_model.sv
// Board controller and portable device model on the mode pins
`timescale 1ns/10ps
module ucpmc_sys_model (
  input  wire       clk_sys,
  input  wire [1:0] reqMode,
  input  wire       dataSwitchOn,
  output reg        modeSelectHi = 1'b0,
  output reg        modeSelectLo = 1'b0,
  output reg        progActive = 1'b0,
  output reg  [1:0] detectStep = 2'h0
);
  always @(posedge clk_sys) begin
    {modeSelectHi, modeSelectLo} <= reqMode;
    progActive <= !modeSelectHi;
    if (!(modeSelectHi && dataSwitchOn)) detectStep <= 2'h0;
    else if (detectStep != 2'h3) detectStep <= detectStep + 2'h1;
  end
endmodule // ucpmc_sys_model

// File: testbench/tb.sv
// Self-checking bench for the charge-port mode control
`timescale 1ns/10ps
module tb;
  logic clk_sys = 1'b0, sys_rst = 1'b1, enableAboveThr = 1'b1, vinUvlo = 1'b0, vccUvlo = 1'b0;
  logic overtempTrip = 1'b0, overtempCool = 1'b0, syncClockValid = 1'b0, currentLimitActive = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, avs_response, buckEnable, activeMode;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf, ditherStep;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [1:0] reqMode = 2'h0, detectStep;
  logic forcedContinuousPwm, freqLockSync, loadSwitchGate, dataSwitchOn;
  logic modeSelectHi, modeSelectLo, progActive;
  int error_cnt = 0, checks = 0;
  ucpmc_mode_ctrl #(.DEGLITCH_CYC(20)) i_dut (.clk_sys, .sys_rst, .modeSelectHi, .modeSelectLo,
    .enableAboveThr, .vinUvlo, .vccUvlo, .overtempTrip, .overtempCool, .syncClockValid,
    .currentLimitActive, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_waitrequest, .avs_readdata, .avs_response, .buckEnable, .forcedContinuousPwm,
    .freqLockSync, .ditherStep, .loadSwitchGate, .dataSwitchOn, .activeMode);
  ucpmc_sys_model i_sys (.clk_sys, .reqMode, .dataSwitchOn, .modeSelectHi, .modeSelectLo,
    .progActive, .detectStep);
  initial forever #12.5 clk_sys = ~clk_sys;
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task pins(input logic [1:0] m, input int n);
    @(posedge clk_sys) reqMode <= m;
    w(n);
  endtask
  task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task t_reset;
    chk("gate", {loadSwitchGate, buckEnable}, 2'h0);
    av(1'b0, 4'h0, 32'h0);
    chk("mode", rd[2:0], 3'h1);
    chk("response", avs_response, 1'b0);
    av(1'b0, 4'h4, 32'h0);
    chk("ctrl", rd, 32'h1);
    av(1'b0, 4'h8, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("t_reset done");
  endtask
  task t_modes;
    pins(2'h2, 7);
    chk("sdp out", {buckEnable, loadSwitchGate, forcedContinuousPwm}, 3'h7);
    av(1'b0, 4'h0, 32'h0);
    chk("sdp mode", rd[2:0], 3'h2);
    av(1'b1, 4'h4, 32'h0);
    w(3);
    chk("dither off", ditherStep, 4'h0);
    av(1'b1, 4'h4, 32'h1);
    w(4);
    chk("dither on", ditherStep !== 4'h0, 1'b1);
    @(posedge clk_sys) currentLimitActive <= 1'b1;
    pins(2'h3, 7);
    av(1'b0, 4'h0, 32'h0);
    chk("cdp mode", rd[2:0], 3'h4);
    chk("detect", {dataSwitchOn, detectStep}, 3'h7);
    $display("t_modes done");
  endtask
  task t_client;
    pins(2'h0, 15);
    chk("deglitch", buckEnable, 1'b1);
    pins(2'h1, 15);
    chk("restart", buckEnable, 1'b1);
    w(15);
    chk("client", {buckEnable, loadSwitchGate, dataSwitchOn, progActive}, 4'h3);
    $display("t_client done");
  endtask
  task t_supply;
    pins(2'h2, 7);
    @(posedge clk_sys) syncClockValid <= 1'b1;
    @(posedge clk_sys) enableAboveThr <= 1'b0;
    w(3);
    chk("shutdown", {dataSwitchOn, activeMode, buckEnable, freqLockSync}, 4'h0);
    @(posedge clk_sys) {enableAboveThr, vinUvlo} <= 2'h3;
    w(3);
    chk("vin uvlo", {activeMode, buckEnable, dataSwitchOn}, 3'h1);
    @(posedge clk_sys) {vinUvlo, vccUvlo} <= 2'h1;
    w(3);
    chk("vcc uvlo", {activeMode, buckEnable, dataSwitchOn}, 3'h1);
    @(posedge clk_sys) vccUvlo <= 1'b0;
    w(3);
    chk("active", {activeMode, buckEnable, freqLockSync}, 3'h7);
    $display("t_supply done");
  endtask
  task t_otp;
    @(posedge clk_sys) overtempTrip <= 1'b1;
    w(2);
    @(posedge clk_sys) overtempTrip <= 1'b0;
    w(3);
    chk("hot", {loadSwitchGate, buckEnable}, 2'h0);
    @(posedge clk_sys) overtempCool <= 1'b0;
    w(10);
    chk("latched", buckEnable, 1'b0);
    @(posedge clk_sys) overtempCool <= 1'b1;
    @(posedge clk_sys) overtempCool <= 1'b0;
    w(4);
    chk("cooled", {loadSwitchGate, buckEnable}, 2'h3);
    $display("t_otp done");
  endtask
  task print_verdict;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    w(1);
    t_reset;
    t_modes;
    t_client;
    t_supply;
    t_otp;
    print_verdict;
  end
  initial begin
    #50000;
    error_cnt++;
    print_verdict;
  end
endmodule // tb
